// ---- design/slsc_regs.svh ----
// Timing, field layout and limit constants of the scan list sequencer
`ifndef SLSC_REGS_SVH
`define SLSC_REGS_SVH
`define SLSC_CLK_HZ 200000000
`define SLSC_MAX_ENTRIES 11
`define SLSC_NUM_ANALOG 8
`define SLSC_NUM_DIG 7
`define SLSC_MAX_DECIM 512
`define SLSC_AGG_RATE_HZ 220000
`define SLSC_ELEM_RATE_HZ 20000
`define SLSC_SLOT_CYCLES ((`SLSC_CLK_HZ + `SLSC_AGG_RATE_HZ - 1) / `SLSC_AGG_RATE_HZ)
`define SLSC_RATE_MIN_HZ 10
`define SLSC_RATE_MAX_HZ 50000
`define SLSC_RATE_RANGES 12
`define SLSC_RANGES 6
`define SLSC_CNT_TERMINAL 16'hFFFF
`define SLSC_ENT_CH_LSB 0
`define SLSC_ENT_RNG_LSB 3
`define SLSC_ENT_KIND_LSB 6
`define SLSC_ENT_W 8
`define SLSC_RES_MIN 12
`define SLSC_RES_MAX 16
`endif

// ---- design/slsc_pkg.sv ----
// Types shared by the scan list sequencer
package slsc_pkg;
    typedef enum logic [1:0] {
        SLSC_KIND_ANALOG = 2'b00,
        SLSC_KIND_DIGITAL = 2'b01,
        SLSC_KIND_COUNT = 2'b10,
        SLSC_KIND_RATE = 2'b11
    } slsc_kind_e;
    typedef enum logic [1:0] {
        SLSC_ST_IDLE = 2'b00,
        SLSC_ST_CONV = 2'b01,
        SLSC_ST_EMIT = 2'b10
    } slsc_state_e;
endpackage

// ---- design/slsc_cic.sv ----
// Per-channel CIC decimator bank sharing one set of integrator/comb math
`timescale 1ns/1ps
`default_nettype none
module slsc_cic #(
    parameter int CH = 8,
    parameter int IN_W = 16,
    parameter int ACC_W = 25
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic [2:0] ch,
    input wire logic sample_valid,
    input wire logic [IN_W-1:0] sample,
    input wire logic [9:0] decim,
    output logic out_valid,
    output logic [ACC_W-1:0] out_sum
);
    logic [ACC_W-1:0] acc_reg [CH];
    logic [9:0] cnt_reg [CH];
    logic [ACC_W-1:0] ext;

    initial begin
        if (ACC_W < IN_W + 9) $error("slsc_cic: ACC_W too small");
    end

    assign ext = {{(ACC_W-IN_W){sample[IN_W-1]}}, sample};

    // Integrate, and dump once decim samples have been summed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < CH; i++) begin
                acc_reg[i] <= '0;
                cnt_reg[i] <= '0;
            end
            out_valid <= 1'b0;
            out_sum <= '0;
        end else begin
            out_valid <= 1'b0;
            if (clear) begin
                for (int i = 0; i < CH; i++) begin
                    acc_reg[i] <= '0;
                    cnt_reg[i] <= '0;
                end
            end else if (sample_valid) begin
                if (cnt_reg[ch] + 10'h001 >= decim) begin
                    // Comb stage: block sum is the dumped integrator
                    out_sum <= acc_reg[ch] + ext;
                    out_valid <= 1'b1;
                    acc_reg[ch] <= '0;
                    cnt_reg[ch] <= '0;
                end else begin
                    acc_reg[ch] <= acc_reg[ch] + ext;
                    cnt_reg[ch] <= cnt_reg[ch] + 10'h001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- design/slsc_top.sv ----
// Scan list sequencer with per-channel CIC filtering
// Overview of operation
// - Each analog channel has a filter whose corner follows the sample rate.
// - Filter is a real-time CIC summing up to 512 converter samples.
// - Scan list holds at most eleven entries of four kinds.
// - Entries of the four kinds may come in any order; a repeated channel or special entry is refused.
// - Each enabled analog channel takes exactly one list position.
// - Analog entries carry physical channel number and range selection.
// - Digital entry samples all seven ports together as one item.
// - One list position reports the counter result.
// - One list position reports the rate measurement result.
// - Throughput up to 220 kHz aggregate, shared equally by the list entries.
// - Slower sampling yields results with more valid bits.
// - Resolution depends on the decimation ratio alone, not on analog channel count.
// - Extra resolution comes from the decimating filter.
// - Range field selects one of six full-scale ranges.
// - Counter reports 16 bits, saturating at all ones.
// - Rate uses one of twelve full-scale ranges.
// - Count is read live in its own slot; rate reports the last completed gate window.
`timescale 1ns/1ps
`default_nettype none
`include "slsc_regs.svh"
module slsc_top
    import slsc_pkg::*;
#(
    parameter int ADC_W = 16,
    parameter int SLOT_CYCLES = `SLSC_SLOT_CYCLES,
    parameter int ACC_W = 25
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic stop,
    input wire logic [3:0] list_len,
    input wire logic [`SLSC_MAX_ENTRIES*`SLSC_ENT_W-1:0] list_entries,
    input wire logic [31:0] slot_interval,
    input wire logic [9:0] decim_ratio,
    input wire logic [3:0] rate_range,
    output logic running,
    output logic config_error,
    output logic adc_start,
    output logic [2:0] adc_channel,
    output logic [2:0] adc_range,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_data,
    input wire logic [`SLSC_NUM_DIG-1:0] dig_in,
    input wire logic count_pulse,
    input wire logic rate_pulse,
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_data,
    output logic [1:0] out_kind,
    output logic [3:0] out_index,
    output logic out_last,
    output logic [4:0] out_bits
);
    localparam int NE = `SLSC_MAX_ENTRIES;
    localparam int EW = `SLSC_ENT_W;

    initial begin
        if (SLOT_CYCLES < 1) $error("slsc_top: SLOT_CYCLES must be >= 1");
        if (ADC_W != 16) $error("slsc_top: ADC_W must be 16");
    end

    slsc_state_e state_reg;
    logic [NE*EW-1:0] list_reg;
    logic [3:0] len_reg;
    logic [31:0] interval_reg;
    logic [9:0] decim_reg;
    logic [3:0] rrange_reg;
    logic [3:0] idx_reg;
    logic [31:0] slot_cnt_reg;
    logic [15:0] count_reg;
    logic [31:0] rate_acc_reg;
    logic [31:0] rate_val_reg;
    logic [31:0] gate_cnt_reg;
    logic pend_reg;
    logic slot_tick;
    logic cfg_bad;
    logic [EW-1:0] cur_entry;
    slsc_kind_e cur_kind;
    logic cic_valid;
    logic [ACC_W-1:0] cic_sum;
    logic emit_now;
    logic [31:0] emit_data;

    // Field extraction of one entry, used for decode and checking
    function automatic logic [EW-1:0] entry_at(input logic [NE*EW-1:0] l,
                                                input logic [3:0] i);
        entry_at = l[i*EW +: EW];
    endfunction

    // Resolution grows by half a bit per doubling of the decimation
    function automatic logic [4:0] res_bits(input logic [9:0] d);
        logic [4:0] b;
        b = 5'(`SLSC_RES_MIN);
        // Steps stop at 256 so every threshold fits the 10-bit ratio
        for (int k = 1; k < 5; k++) begin
            if (d >= 10'(1 << (2 * k)) && b < 5'(`SLSC_RES_MAX)) b = b + 5'h01;
        end
        res_bits = b;
    endfunction

    // Rate gate time per range: 2^k * 1 ms, range 0 finest
    function automatic logic [31:0] gate_cycles(input logic [3:0] r);
        gate_cycles = 32'(`SLSC_CLK_HZ / 1000) << r;
    endfunction

    // Reject lists with duplicate special entries, bad ranges or length
    always_comb begin
        logic [3:0] nd;
        logic [3:0] nc;
        logic [3:0] nr;
        logic [7:0] chseen;
        logic bad;
        logic [EW-1:0] e;
        nd = '0;
        nc = '0;
        nr = '0;
        chseen = '0;
        e = '0;
        bad = (list_len == 4'h0) || (list_len > 4'(NE)) ||
              (decim_ratio == 10'h000) || (decim_ratio > 10'(`SLSC_MAX_DECIM))
              || (rate_range >= 4'(`SLSC_RATE_RANGES));
        for (int i = 0; i < NE; i++) begin
            e = entry_at(list_entries, 4'(i));
            if (4'(i) < list_len) begin
                case (slsc_kind_e'(e[`SLSC_ENT_KIND_LSB +: 2]))
                    SLSC_KIND_ANALOG: begin
                        if (chseen[e[2:0]]) bad = 1'b1;
                        chseen[e[2:0]] = 1'b1;
                        if (e[`SLSC_ENT_RNG_LSB +: 3] >= 3'(`SLSC_RANGES))
                            bad = 1'b1;
                    end
                    SLSC_KIND_DIGITAL: nd = nd + 4'h1;
                    SLSC_KIND_COUNT: nc = nc + 4'h1;
                    default: nr = nr + 4'h1;
                endcase
            end
        end
        if (nd > 4'h1 || nc > 4'h1 || nr > 4'h1) bad = 1'b1;
        cfg_bad = bad;
    end

    assign cur_entry = entry_at(list_reg, idx_reg);
    assign cur_kind = slsc_kind_e'(cur_entry[`SLSC_ENT_KIND_LSB +: 2]);
    assign slot_tick = (slot_cnt_reg == 32'h0000_0000);

    // Config is captured at start only; inputs ignored while running
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            list_reg <= '0;
            len_reg <= 4'h0;
            interval_reg <= 32'h0000_0001;
            decim_reg <= 10'h001;
            rrange_reg <= 4'h0;
            config_error <= 1'b0;
        end else if (state_reg == SLSC_ST_IDLE && start) begin
            config_error <= cfg_bad;
            list_reg <= list_entries;
            len_reg <= list_len;
            decim_reg <= decim_ratio;
            rrange_reg <= rate_range;
            // Never let a slot be shorter than the aggregate limit
            interval_reg <= (slot_interval < 32'(SLOT_CYCLES)) ?
                            32'(SLOT_CYCLES) : slot_interval;
        end
    end

    // Sequencer state: idle, wait for conversion, emit item
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= SLSC_ST_IDLE;
            idx_reg <= 4'h0;
            slot_cnt_reg <= 32'h0000_0000;
            adc_start <= 1'b0;
            adc_channel <= 3'h0;
            adc_range <= 3'h0;
            pend_reg <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            case (state_reg)
                SLSC_ST_IDLE: begin
                    idx_reg <= 4'h0;
                    slot_cnt_reg <= 32'h0000_0000;
                    pend_reg <= 1'b0;
                    if (start && !cfg_bad) state_reg <= SLSC_ST_CONV;
                end
                SLSC_ST_CONV: begin
                    if (stop) begin
                        state_reg <= SLSC_ST_IDLE;
                    end else if (slot_tick) begin
                        // One entry per slot, no idle slot between scans
                        slot_cnt_reg <= interval_reg - 32'h0000_0001;
                        if (cur_kind == SLSC_KIND_ANALOG) begin
                            adc_start <= 1'b1;
                            adc_channel <= cur_entry[`SLSC_ENT_CH_LSB +: 3];
                            adc_range <= cur_entry[`SLSC_ENT_RNG_LSB +: 3];
                            pend_reg <= 1'b1;
                        end else begin
                            state_reg <= SLSC_ST_EMIT;
                        end
                    end else begin
                        slot_cnt_reg <= slot_cnt_reg - 32'h0000_0001;
                        if (adc_done) pend_reg <= 1'b0;
                        if (pend_reg && adc_done) state_reg <= SLSC_ST_EMIT;
                    end
                end
                SLSC_ST_EMIT: begin
                    if (slot_cnt_reg != 32'h0000_0000)
                        slot_cnt_reg <= slot_cnt_reg - 32'h0000_0001;
                    // Analog leaves after one cycle; others once loaded
                    if (emit_now || cur_kind == SLSC_KIND_ANALOG) begin
                        idx_reg <= (idx_reg + 4'h1 >= len_reg) ? 4'h0 :
                                   idx_reg + 4'h1;
                        state_reg <= stop ? SLSC_ST_IDLE : SLSC_ST_CONV;
                    end
                end
                default: state_reg <= SLSC_ST_IDLE;
            endcase
        end
    end

    // Per-channel CIC; corner follows decimation, so it tracks the rate
    slsc_cic #(
        .CH(`SLSC_NUM_ANALOG),
        .IN_W(ADC_W),
        .ACC_W(ACC_W)
    ) u_cic (
        .clk(clk),
        .reset_n(reset_n),
        .clear(state_reg == SLSC_ST_IDLE),
        .ch(adc_channel),
        .sample_valid(pend_reg && adc_done && state_reg == SLSC_ST_CONV),
        .sample(adc_data),
        .decim(decim_reg),
        .out_valid(cic_valid),
        .out_sum(cic_sum)
    );

    // Non-analog item loads only into a free output register, so the
    // handshake of an earlier stalled item is never taken for this one
    assign emit_now = (state_reg == SLSC_ST_EMIT) &&
                      (cur_kind != SLSC_KIND_ANALOG) &&
                      (!out_valid || out_ready);

    // Counter input saturates at terminal count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 16'h0000;
        end else if (state_reg == SLSC_ST_IDLE && start) begin
            count_reg <= 16'h0000;
        end else if (count_pulse && count_reg != `SLSC_CNT_TERMINAL) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Rate: count pulses over a range-dependent gate time
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rate_acc_reg <= 32'h0000_0000;
            rate_val_reg <= 32'h0000_0000;
            gate_cnt_reg <= 32'h0000_0000;
        end else if (gate_cnt_reg >= gate_cycles(rrange_reg) - 32'h1) begin
            rate_val_reg <= rate_acc_reg + {31'h0, rate_pulse};
            rate_acc_reg <= 32'h0000_0000;
            gate_cnt_reg <= 32'h0000_0000;
        end else begin
            rate_acc_reg <= rate_acc_reg + {31'h0, rate_pulse};
            gate_cnt_reg <= gate_cnt_reg + 32'h0000_0001;
        end
    end

    // Pick the item word; the CIC sum is sign-extended to 32 bits, unscaled
    always_comb begin
        case (cur_kind)
            SLSC_KIND_DIGITAL: emit_data = {25'h0, dig_in};
            SLSC_KIND_COUNT: emit_data = {16'h0, count_reg};
            SLSC_KIND_RATE: emit_data = rate_val_reg;
            default: emit_data = 32'(signed'(cic_sum));
        endcase
    end

    // Output item register; held until the consumer accepts it.
    // No buffer: a filter result meeting a held item is dropped, so the
    // consumer must take each item within one slot
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_data <= 32'h0000_0000;
            out_kind <= 2'h0;
            out_index <= 4'h0;
            out_last <= 1'b0;
            out_bits <= 5'h00;
        end else if (out_valid && !out_ready) begin
            out_valid <= 1'b1;
        end else if (emit_now || cic_valid) begin
            out_valid <= 1'b1;
            out_data <= emit_data;
            out_kind <= cur_kind;
            out_index <= idx_reg;
            out_last <= (idx_reg + 4'h1 >= len_reg);
            out_bits <= (cur_kind == SLSC_KIND_ANALOG) ?
                        res_bits(decim_reg) : 5'h10;
        end else begin
            out_valid <= 1'b0;
        end
    end

    assign running = (state_reg != SLSC_ST_IDLE);
endmodule
`default_nettype wire

// ---- bench/slsc_asserts.sv ----
// Concurrent checks on the scan list sequencer ports
`timescale 1ns/1ps
`default_nettype none
module slsc_asserts
    import slsc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic running,
    input wire logic config_error,
    input wire logic adc_start,
    input wire logic [2:0] adc_range,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [31:0] out_data,
    input wire logic [1:0] out_kind,
    input wire logic [3:0] out_index,
    input wire logic [4:0] out_bits
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // An offered item is frozen until the host takes it
    sequence stalled_s;
        out_valid && !out_ready;
    endsequence
    sequence held_s;
        out_valid && $stable(out_data) && $stable(out_index);
    endsequence
    item_hold_a: assert property (stalled_s |=> held_s)
        else $error("output item changed while stalled");
    conv_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("conversion request longer than one cycle");
    range_sel_a: assert property (adc_start |-> adc_range <= 3'h5)
        else $error("range code outside six ranges");
    res_span_a: assert property (out_valid |->
        out_bits >= 5'h0C && out_bits <= 5'h10)
        else $error("resolution outside 12 to 16 bits");
    aux_res_a: assert property (out_valid &&
        out_kind != SLSC_KIND_ANALOG |-> out_bits == 5'h10)
        else $error("non-analog item not full width");
    count_width_a: assert property (out_valid &&
        out_kind == SLSC_KIND_COUNT |-> out_data[31:16] == 16'h0000)
        else $error("count result wider than 16 bits");
    list_bound_a: assert property (out_valid |-> out_index <= 4'hA)
        else $error("item index beyond eleven entries");
    refuse_idle_a: assert property (config_error |-> !running)
        else $error("running with a refused list");
    idle_conv_a: assert property (!running |-> !adc_start)
        else $error("conversion requested while idle");
endmodule
bind slsc_top slsc_asserts u_slsc_asserts (.clk(clk), .reset_n(reset_n),
    .running(running), .config_error(config_error), .adc_start(adc_start),
    .adc_range(adc_range), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_kind(out_kind), .out_index(out_index),
    .out_bits(out_bits));
`default_nettype wire

// ---- bench/slsc_host_model.sv ----
// Host stream consumer with a converter responder
`timescale 1ns/1ps
`default_nettype none
module slsc_host_model #(
    parameter int ADC_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic adc_start,
    output logic adc_done,
    output logic [ADC_W-1:0] adc_data,
    input wire logic out_valid,
    output logic out_ready
);
    int seed = 32'h5A17C3E1;
    int wait_n = 0;
    logic slow = 1'b0;
    int low_n = 0;
    initial begin
        adc_done = 1'b0;
        adc_data = '0;
        out_ready = 1'b0;
    end
    // Prompt and slow answers by turns; data is scrambled outside
    // the done cycle so a stale word can never pass for a result
    // Ready drops at random but never for more than two cycles running,
    // as a host that keeps up with the slot rate
    always @(negedge clk) begin
        if (!reset_n || low_n >= 2 || $random(seed) % 4 != 0) begin
            out_ready <= reset_n;
            low_n <= 0;
        end else begin
            out_ready <= 1'b0;
            low_n <= low_n + 1;
        end
        if (wait_n == 1) begin
            adc_done <= 1'b1;
            adc_data <= ADC_W'($random(seed));
        end else begin
            adc_done <= 1'b0;
            adc_data <= ~adc_data;
        end
        if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end else if (adc_start && reset_n) begin
            wait_n <= slow ? 4 : 1;
            slow <= !slow;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_slsc_top.sv ----
// Self-checking bench for the scan list sequencer
`timescale 1ns/1ps
`default_nettype none
`include "slsc_regs.svh"
module tb_slsc_top
    import slsc_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, start = 1'b0, stop = 1'b0;
    logic [3:0] list_len = 4'h0, rate_range = 4'h3;
    logic [`SLSC_MAX_ENTRIES*`SLSC_ENT_W-1:0] list_entries = '0;
    logic [31:0] slot_interval = 32'h00000008;
    logic [9:0] decim_ratio = 10'h001;
    logic [6:0] dig_in = 7'h00;
    logic count_pulse = 1'b0, rate_pulse = 1'b0;
    logic adc_done, out_ready, running, config_error, adc_start;
    logic out_valid, out_last;
    logic [2:0] adc_channel, adc_range;
    logic [15:0] adc_data;
    logic [31:0] out_data;
    logic [1:0] out_kind;
    logic [3:0] out_index;
    logic [4:0] out_bits;
    logic [11:0] exp_q[$];
    logic [11:0] got;
    int seed = 32'hA82E2839;
    int miscompares = 0, n_compared = 0, cycles = 0;
    slsc_top #(.SLOT_CYCLES(8)) u_slsc_top (.clk(clk), .reset_n(reset_n),
        .start(start), .stop(stop), .list_len(list_len),
        .list_entries(list_entries), .slot_interval(slot_interval),
        .decim_ratio(decim_ratio), .rate_range(rate_range),
        .running(running), .config_error(config_error),
        .adc_start(adc_start), .adc_channel(adc_channel),
        .adc_range(adc_range), .adc_done(adc_done), .adc_data(adc_data),
        .dig_in(dig_in), .count_pulse(count_pulse),
        .rate_pulse(rate_pulse), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data), .out_kind(out_kind),
        .out_index(out_index), .out_last(out_last), .out_bits(out_bits));
    slsc_host_model u_slsc_host_model (.clk(clk), .reset_n(reset_n),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
        .out_valid(out_valid), .out_ready(out_ready));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic check(string what, logic [31:0] e, logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Note one scan: entries in list order, the last one flagged
    task automatic expect_scan(int n, logic [4:0] bits);
        logic [1:0] k;
        for (int i = 0; i < n; i++) begin
            k = list_entries[8*i+6 +: 2];
            exp_q.push_back({k, 4'(i), i == n - 1, k == 2'h0 ? bits : 5'h10});
        end
    endtask
    // Start, scramble the list mid-run, stop once notes are used up
    task automatic run(int limit);
        int t;
        int quiet;
        @(negedge clk) start = 1'b1;
        @(negedge clk) start = 1'b0;
        list_entries = 88'({3{32'($random(seed))}});
        t = 0;
        while (exp_q.size() > 0 && t < limit) begin
            @(negedge clk);
            t++;
        end
        check("drained", 32'h0, 32'(exp_q.size()));
        stop = 1'b1;
        t = 0;
        quiet = 0;
        // A result already inside the filter may surface just after idle
        while (quiet < 4 && t < 200) begin
            @(negedge clk);
            t++;
            quiet = (running === 1'b0 && out_valid === 1'b0) ? quiet + 1 : 0;
        end
        stop = 1'b0;
        check("stopped", 32'h0, {31'h0, running});
        exp_q.delete();
    endtask
    // Oldest note is paired with each item the host accepts
    always @(posedge clk) begin
        if (reset_n && out_valid === 1'b1 && out_ready === 1'b1 &&
            exp_q.size() > 0) begin
            got = exp_q.pop_front();
            check("item", {20'h0, got}, {20'h0, out_kind, out_index,
                out_last, out_bits});
            if (out_kind === SLSC_KIND_DIGITAL)
                check("ports", {25'h0, dig_in}, {25'h0, out_data[6:0]});
        end
        if (adc_start === 1'b1)
            check("range", {29'h0, adc_channel % 3'h6}, {29'h0, adc_range});
    end
    // Pulse inputs toggle at random off the sampling edge
    always @(negedge clk) begin
        count_pulse <= 1'($random(seed));
        rate_pulse <= 1'($random(seed));
    end
    // Hang guard sized well above the longest scenario
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 9000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        dig_in = 7'($random(seed));
        // Two entries on one analog channel are refused
        list_len = 4'h2;
        @(negedge clk) start = 1'b1;
        @(negedge clk) start = 1'b0;
        @(negedge clk);
        check("refused", 32'h1, {31'h0, config_error});
        check("idle", 32'h0, {31'h0, running});
        // Full list: eight analog, then digital, count and rate
        list_len = 4'hB;
        for (int i = 0; i < 8; i++)
            list_entries[8*i +: 8] = {2'h0, 3'(i % 6), 3'(i)};
        list_entries[64 +: 24] = {8'hC0, 8'h80, 8'h40};
        repeat (2) expect_scan(11, 5'h0C);
        run(260);
        // Special entries first, analog last, several wraps
        list_len = 4'h4;
        list_entries[31:0] = {8'h2D, 8'h40, 8'h80, 8'hC0};
        repeat (3) expect_scan(4, 5'h0C);
        run(220);
        // Longest CIC sum on one channel gives the most valid bits
        list_len = 4'h1;
        list_entries[7:0] = 8'h2D;
        decim_ratio = 10'h200;
        expect_scan(1, 5'h10);
        run(4500);
        stop_test();
    end
endmodule
`default_nettype wire
